// ===== rtl/hcirq_pkg.sv
// Shared constants for the host event status block and its driver end.
// Assumes both ends run on one clock and meet through hcirq_if.
package hcirq_pkg;
    localparam int FLAG_W = 10;
    localparam int REG_W = 16;
    localparam logic [7:0] CMD_RD_STATUS = 8'h24;
    localparam logic [7:0] CMD_WR_STATUS = 8'ha4;
    localparam logic [7:0] CMD_RD_ENABLE = 8'h25;
    localparam logic [7:0] CMD_WR_ENABLE = 8'ha5;
    localparam logic [FLAG_W-1:0] STATUS_RST = 10'h000;
    localparam logic [FLAG_W-1:0] ENABLE_RST = 10'h000;
    localparam logic [FLAG_W-1:0] FLAG_MASK = 10'h3ff;
    localparam int BIT_DUAL_ROLE = 9;
    localparam int BIT_ASYNC_THR = 8;
    localparam int BIT_PERIODIC = 7;
    localparam int BIT_WAKE_CLK = 6;
    localparam int BIT_SUSPENDED = 5;
    localparam int BIT_OPER_IRQ = 4;
    localparam int BIT_XFER_DONE = 3;
    localparam int BIT_ISO_BUF1 = 2;
    localparam int BIT_ISO_BUF0 = 1;
    localparam int BIT_SOF = 0;
    typedef enum logic [1:0] {
        HCIRQ_IDLE,
        HCIRQ_WAIT
    } hcirq_state_t;
endpackage

// ===== rtl/hcirq_if.sv
// Command link between the host driver end and the event status end.
// Assumes one shared clock; a command is taken when cmd_valid is high.
`timescale 1ns/1ns
interface hcirq_if (
    input wire logic clk_i
);
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [15:0] wr_data;
    logic rd_valid;
    logic [15:0] rd_data;
    logic irq;

    modport dev (
        input cmd_valid,
        input cmd_code,
        input wr_data,
        output rd_valid,
        output rd_data,
        output irq
    );

    modport host (
        output cmd_valid,
        output cmd_code,
        output wr_data,
        input rd_valid,
        input rd_data,
        input irq
    );
endinterface

// ===== rtl/hcirq_dev.sv
// Host event status register with per-bit enable and global interrupt gate.
// Assumes event inputs are one-cycle pulses or levels on clk_i.
`timescale 1ns/1ns
module hcirq_dev (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Command link
    hcirq_if.dev bus,
    // Event sources
    input wire logic dual_role_event_i,
    input wire logic async_count_hit_i,
    input wire logic async_timeout_hit_i,
    input wire logic periodic_last_done_i,
    input wire logic periodic_any_ack_i,
    input wire logic wake_clock_ok_i,
    input wire logic suspend_enter_i,
    input wire logic operational_irq_i,
    input wire logic byte_count_zero_i,
    input wire logic end_of_transfer_pin_i,
    input wire logic iso_buf1_done_i,
    input wire logic iso_buf0_done_i,
    input wire logic sof_state_i,
    // Configuration
    input wire logic global_irq_en_i,
    // Status
    output logic sof_allowed_o,
    output logic [9:0] status_o
);
    // ********************************
    // Pin synchronisers
    // ********************************
    // The end-of-transfer pin comes from outside the clock domain.
    // The third stage only serves the edge detector, so a held pin sets the flag once.
    logic eot_s1_q, eot_s2_q, eot_s3_q;
    logic eot_s1_d, eot_s2_d, eot_s3_d;
    always_comb begin
        eot_s1_d = end_of_transfer_pin_i;
        eot_s2_d = eot_s1_q;
        eot_s3_d = eot_s2_q;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            eot_s1_q <= 1'b0;
            eot_s2_q <= 1'b0;
            eot_s3_q <= 1'b0;
        end else begin
            eot_s1_q <= eot_s1_d;
            eot_s2_q <= eot_s2_d;
            eot_s3_q <= eot_s3_d;
        end
    end

    // ********************************
    // Command decode
    // ********************************
    // One decoder for all four codes keeps the read and write paths in step.
    function automatic logic cmd_is(input logic valid, input logic [7:0] code, input logic [7:0] want);
        cmd_is = valid && (code == want);
    endfunction

    // ********************************
    // Suspend tracking
    // ********************************
    // A suspend request in the wake cycle wins, so the frame gate never reopens early.
    logic suspended_q, suspended_d;
    always_comb begin
        suspended_d = suspended_q;
        if (suspend_enter_i) begin
            suspended_d = 1'b1;
        end else if (wake_clock_ok_i) begin
            suspended_d = 1'b0;
        end
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            suspended_q <= 1'b0;
        end else begin
            suspended_q <= suspended_d;
        end
    end

    // ********************************
    // Event flags
    // ********************************
    logic [hcirq_pkg::FLAG_W-1:0] set_vec;
    logic [hcirq_pkg::FLAG_W-1:0] flags_q, flags_d;
    logic [hcirq_pkg::FLAG_W-1:0] enable_q, enable_d;
    logic wr_status, wr_enable, rd_status, rd_enable;

    always_comb begin
        wr_status = cmd_is(bus.cmd_valid, bus.cmd_code, hcirq_pkg::CMD_WR_STATUS);
        rd_status = cmd_is(bus.cmd_valid, bus.cmd_code, hcirq_pkg::CMD_RD_STATUS);
        wr_enable = cmd_is(bus.cmd_valid, bus.cmd_code, hcirq_pkg::CMD_WR_ENABLE);
        rd_enable = cmd_is(bus.cmd_valid, bus.cmd_code, hcirq_pkg::CMD_RD_ENABLE);
        set_vec = '0;
        set_vec[hcirq_pkg::BIT_DUAL_ROLE] = dual_role_event_i;
        set_vec[hcirq_pkg::BIT_ASYNC_THR] = async_count_hit_i | async_timeout_hit_i;
        set_vec[hcirq_pkg::BIT_PERIODIC] = periodic_last_done_i & periodic_any_ack_i;
        set_vec[hcirq_pkg::BIT_WAKE_CLK] = wake_clock_ok_i;
        set_vec[hcirq_pkg::BIT_SUSPENDED] = suspend_enter_i;
        set_vec[hcirq_pkg::BIT_OPER_IRQ] = operational_irq_i;
        set_vec[hcirq_pkg::BIT_XFER_DONE] = byte_count_zero_i | (eot_s2_q & ~eot_s3_q);
        set_vec[hcirq_pkg::BIT_ISO_BUF1] = iso_buf1_done_i;
        set_vec[hcirq_pkg::BIT_ISO_BUF0] = iso_buf0_done_i;
        set_vec[hcirq_pkg::BIT_SOF] = sof_state_i & ~suspended_q;
        // Clearing before setting lets an event in the clearing cycle survive.
        // write-one clear, set wins
        flags_d = flags_q;
        if (wr_status) begin
            flags_d = flags_q & ~bus.wr_data[hcirq_pkg::FLAG_W-1:0];
        end
        flags_d = flags_d | set_vec;
        // The enable mask lives here so the pin gate needs no extra port.
        enable_d = enable_q;
        if (wr_enable) begin
            enable_d = bus.wr_data[hcirq_pkg::FLAG_W-1:0] & hcirq_pkg::FLAG_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_q <= hcirq_pkg::STATUS_RST;
            enable_q <= hcirq_pkg::ENABLE_RST;
        end else begin
            flags_q <= flags_d;
            enable_q <= enable_d;
        end
    end

    // ********************************
    // Read path and outputs
    // ********************************
    logic rd_valid_q, rd_valid_d;
    logic [hcirq_pkg::REG_W-1:0] rd_data_q, rd_data_d;
    logic irq_q, irq_d;
    logic sof_ok_q, sof_ok_d;

    always_comb begin
        rd_valid_d = rd_status | rd_enable;
        rd_data_d = rd_data_q;
        // A read returns the flags before this edge; a flag set now shows next time.
        // reserved bits zero
        if (rd_status) begin
            rd_data_d = {6'h00, flags_q};
        end else if (rd_enable) begin
            rd_data_d = {6'h00, enable_q};
        end
        // Next values let the pin follow a new flag or enable one cycle sooner.
        // gated interrupt pin
        irq_d = global_irq_en_i & (|(flags_d & enable_d));
        sof_ok_d = ~suspended_d;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= '0;
            irq_q <= 1'b0;
            sof_ok_q <= 1'b1;
        end else begin
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            irq_q <= irq_d;
            sof_ok_q <= sof_ok_d;
        end
    end

    assign bus.rd_valid = rd_valid_q;
    assign bus.rd_data = rd_data_q;
    assign bus.irq = irq_q;
    assign sof_allowed_o = sof_ok_q;
    assign status_o = flags_q;
endmodule

// ===== rtl/hcirq_host.sv
// Driver end: issues read and write commands to the event status block.
// Assumes a user side that raises one request at a time and waits for done.
`timescale 1ns/1ns
module hcirq_host (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Command link
    hcirq_if.host bus,
    // User requests
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_enable_reg_i,
    input wire logic [15:0] req_data_i,
    // User answers
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic irq_o
);
    logic cmd_valid_q, cmd_valid_d;
    logic [7:0] cmd_code_q, cmd_code_d;
    logic [15:0] wr_data_q, wr_data_d;
    logic done_q, done_d;
    logic [15:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    hcirq_pkg::hcirq_state_t state_q, state_d;

    always_comb begin
        state_d = state_q;
        cmd_valid_d = 1'b0;
        cmd_code_d = cmd_code_q;
        wr_data_d = wr_data_q;
        done_d = 1'b0;
        rdata_d = rdata_q;
        irq_d = bus.irq;
        case (state_q)
            hcirq_pkg::HCIRQ_IDLE: begin
                if (req_i) begin
                    cmd_valid_d = 1'b1;
                    wr_data_d = req_data_i;
                    if (req_write_i) begin
                        cmd_code_d = req_enable_reg_i ? hcirq_pkg::CMD_WR_ENABLE : hcirq_pkg::CMD_WR_STATUS;
                    end else begin
                        cmd_code_d = req_enable_reg_i ? hcirq_pkg::CMD_RD_ENABLE : hcirq_pkg::CMD_RD_STATUS;
                    end
                    state_d = hcirq_pkg::HCIRQ_WAIT;
                end
            end
            hcirq_pkg::HCIRQ_WAIT: begin
                // Writes finish at once; reads wait for the returned word.
                if (cmd_code_q[7]) begin
                    done_d = 1'b1;
                    state_d = hcirq_pkg::HCIRQ_IDLE;
                end else if (bus.rd_valid) begin
                    done_d = 1'b1;
                    rdata_d = bus.rd_data;
                    state_d = hcirq_pkg::HCIRQ_IDLE;
                end
            end
            default: begin
                state_d = hcirq_pkg::HCIRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= hcirq_pkg::HCIRQ_IDLE;
            cmd_valid_q <= 1'b0;
            cmd_code_q <= 8'h00;
            wr_data_q <= 16'h0000;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_valid_q <= cmd_valid_d;
            cmd_code_q <= cmd_code_d;
            wr_data_q <= wr_data_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign bus.cmd_valid = cmd_valid_q;
    assign bus.cmd_code = cmd_code_q;
    assign bus.wr_data = wr_data_q;
    assign done_o = done_q;
    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
endmodule

// ===== tb/hcirq_properties.sv
// Concurrent checks on the command link between the host and device ends.
// Assumes one clock; the bench top instantiates this beside hcirq_if.
`timescale 1ns/1ns
module hcirq_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Command link
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] wr_data,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic irq
);
    // ********************
    // Read requests
    // ********************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic is_rd;
    assign is_rd = cmd_valid && (cmd_code == hcirq_pkg::CMD_RD_STATUS || cmd_code == hcirq_pkg::CMD_RD_ENABLE);
    // ********************
    // Assertions
    // ********************
    chk_read_answer:
    assert property (is_rd |=> rd_valid) else $error("read command got no answer");
    chk_no_stray_answer:
    assert property (!is_rd |=> !rd_valid) else $error("answer without read command");
    chk_answer_pulse:
    assert property (rd_valid |=> !rd_valid) else $error("answer longer than one cycle");
    chk_reserved_zero:
    assert property (rd_valid |-> rd_data[15:10] == 6'h00) else $error("reserved bits read nonzero");
    chk_read_data_holds:
    assert property (!rd_valid |-> $stable(rd_data)) else $error("read data moved without answer");
    chk_irq_masked:
    assert property (cmd_valid && cmd_code == hcirq_pkg::CMD_WR_ENABLE && wr_data[9:0] == 10'h000 |=> !irq)
        else $error("interrupt with all enables off");
    chk_cmd_spacing:
    assert property (cmd_valid |=> !cmd_valid) else $error("commands too close");
    chk_write_silent:
    assert property (cmd_valid && cmd_code == hcirq_pkg::CMD_WR_STATUS |=> !rd_valid [*2])
        else $error("write produced an answer");
endmodule

// ===== tb/tb_host_ctrl_irq_status.sv
// Bench joining both ends; reads are noted in a queue and checked on the link.
// Assumes a 125 MHz clock and event sources driven directly by the bench.
`timescale 1ns/1ns
module tb_host_ctrl_irq_status;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic req_enable_reg_i = 1'b0;
    logic [15:0] req_data_i = 16'h0000;
    logic [12:0] ev = 13'h0000;
    logic glob = 1'b0;
    logic done_o;
    logic [15:0] rdata_o;
    logic irq_o;
    logic sof_allowed_o;
    logic [9:0] status_o;
    logic [15:0] exp_q[$];
    logic [9:0] exp;
    logic [31:0] rnd;
    logic susp;
    int checks = 0;
    int n_mismatch = 0;
    int bit_of[13] = '{9, 8, 8, 7, 7, 6, 5, 4, 3, 3, 2, 1, 0};
    always #4 clk_i = ~clk_i;
    // ********************
    // Design ends
    // ********************
    hcirq_if hcirq_if_i (.clk_i(clk_i));
    hcirq_dev hcirq_dev_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(hcirq_if_i), .dual_role_event_i(ev[0]),
        .async_count_hit_i(ev[1]), .async_timeout_hit_i(ev[2]), .periodic_last_done_i(ev[3]),
        .periodic_any_ack_i(ev[4]), .wake_clock_ok_i(ev[5]), .suspend_enter_i(ev[6]), .operational_irq_i(ev[7]),
        .byte_count_zero_i(ev[8]), .end_of_transfer_pin_i(ev[9]), .iso_buf1_done_i(ev[10]),
        .iso_buf0_done_i(ev[11]), .sof_state_i(ev[12]), .global_irq_en_i(glob), .sof_allowed_o(sof_allowed_o),
        .status_o(status_o));
    hcirq_host hcirq_host_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(hcirq_if_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_enable_reg_i(req_enable_reg_i), .req_data_i(req_data_i),
        .done_o(done_o), .rdata_o(rdata_o), .irq_o(irq_o));
    hcirq_properties hcirq_properties_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid(hcirq_if_i.cmd_valid),
        .cmd_code(hcirq_if_i.cmd_code), .wr_data(hcirq_if_i.wr_data), .rd_valid(hcirq_if_i.rd_valid),
        .rd_data(hcirq_if_i.rd_data), .irq(hcirq_if_i.irq));
    // ********************
    // Tasks
    // ********************
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] expv, input logic [15:0] seen);
        checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
        end
    endtask
    // The event mask is raised so that it is sampled at the edge the command is taken.
    task automatic op(input logic wr, input logic en, input logic [15:0] d, input logic [12:0] evm);
        int k;
        @(negedge clk_i);
        req_i = 1'b1;
        req_write_i = wr;
        req_enable_reg_i = en;
        req_data_i = d;
        @(negedge clk_i);
        req_i = 1'b0;
        ev = evm;
        @(negedge clk_i);
        ev = 13'h0000;
        for (k = 0; k < 8 && done_o !== 1'b1; k++) @(negedge clk_i);
        if (k == 8) begin
            n_mismatch++;
            $display("CHECK FAILED done_o expected 1 seen 0");
            end_of_test();
        end
    endtask
    task automatic rd(input logic en, input logic [15:0] expv);
        exp_q.push_back(expv);
        op(1'b0, en, 16'h0000, 13'h0000);
        check("rdata_o", expv, rdata_o);
        if (!en) check("status_o", expv, {6'h00, status_o});
    endtask
    task automatic pulse(input logic [12:0] m, input int n);
        @(negedge clk_i);
        ev = m;
        repeat (n) @(negedge clk_i);
        ev = 13'h0000;
        repeat (5) @(negedge clk_i);
    endtask
    // ********************
    // Answer monitor
    // ********************
    always @(negedge clk_i) begin
        if (hcirq_if_i.rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("CHECK FAILED rd_valid expected none seen 1");
            end else begin
                check("rd_data", exp_q.pop_front(), hcirq_if_i.rd_data);
            end
        end
    end
    // ********************
    // Main sequence
    // ********************
    initial begin
        rnd = $urandom(32'h5381);
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        exp = 10'h000;
        susp = 1'b0;
        rd(1'b0, 16'h0000);
        rd(1'b1, 16'h0000);
        for (int i = 0; i < 13; i++) begin
            if (i == 9) begin
                op(1'b1, 1'b0, 16'h0008, 13'h0000);
                exp[3] = 1'b0;
                rd(1'b0, {6'h00, exp});
            end
            pulse(i == 3 ? 13'h0018 : (i == 4 ? 13'h0008 : 13'h0001 << i), i == 9 ? 2 : 1);
            if (i != 4 && !(i == 12 && susp)) exp[bit_of[i]] = 1'b1;
            if (i == 6) susp = 1'b1;
            rd(1'b0, {6'h00, exp});
            rd(1'b0, {6'h00, exp});
        end
        check("sof_allowed_o", 16'h0000, {15'h0000, sof_allowed_o});
        pulse(13'h0020, 1);
        check("sof_allowed_o", 16'h0001, {15'h0000, sof_allowed_o});
        pulse(13'h1000, 1);
        exp[0] = 1'b1;
        op(1'b1, 1'b0, 16'hfc00, 13'h0000);
        rd(1'b0, {6'h00, exp});
        op(1'b1, 1'b0, 16'h00ff, 13'h0000);
        exp = exp & 10'h300;
        rd(1'b0, {6'h00, exp});
        for (int j = 0; j < 4; j++) begin
            pulse(13'h0d9b, 1);
            exp = exp | 10'h39e;
            rnd = $urandom;
            op(1'b1, 1'b0, rnd[15:0], 13'h0000);
            exp = exp & ~rnd[9:0];
            rd(1'b0, {6'h00, exp});
        end
        op(1'b1, 1'b0, 16'h03ff, 13'h0001);
        rd(1'b0, 16'h0200);
        op(1'b1, 1'b1, 16'h0100, 13'h0000);
        glob = 1'b1;
        repeat (3) @(negedge clk_i);
        check("irq_o", 16'h0000, {15'h0000, irq_o});
        op(1'b1, 1'b1, 16'h0200, 13'h0000);
        repeat (2) @(negedge clk_i);
        check("irq_o", 16'h0001, {15'h0000, irq_o});
        glob = 1'b0;
        repeat (3) @(negedge clk_i);
        check("irq_o", 16'h0000, {15'h0000, irq_o});
        rd(1'b1, 16'h0200);
        glob = 1'b1;
        op(1'b1, 1'b1, 16'h0000, 13'h0000);
        repeat (2) @(negedge clk_i);
        check("irq_o", 16'h0000, {15'h0000, irq_o});
        arst_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        arst_n_i = 1'b1;
        rd(1'b0, 16'h0000);
        repeat (4) @(negedge clk_i);
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("CHECK FAILED rd_valid expected %0d more seen none", exp_q.size());
        end
        end_of_test();
    end
endmodule
